// >>> core/drcc_pkg.sv
/*
 * drcc_pkg: register offsets, field positions, reset values and phase
 * arithmetic constants for the data receiver and clock input control bank.
 * Assumes an 8-bit register space reached through the serial config port.
 */
package drcc_pkg;

	// register offsets
	localparam logic [7:0] ADDR_PHASE_CTRL  = 8'h0a;
	localparam logic [7:0] ADDR_WARN_CLEAR  = 8'h0b;
	localparam logic [7:0] ADDR_TUNING      = 8'h0c;
	localparam logic [7:0] ADDR_RATE_MODE   = 8'h0d;
	localparam logic [7:0] ADDR_STATUS      = 8'h0e;
	localparam logic [7:0] ADDR_SAMPLE_CLK  = 8'h10;
	localparam logic [7:0] ADDR_REF_CLK     = 8'h11;

	// reset values
	localparam logic [7:0] RST_PHASE_CTRL   = 8'h40;
	localparam logic [6:0] RST_WARN_RSV     = 7'h39;
	localparam logic [7:0] RST_TUNING       = 8'h64;
	localparam logic [7:0] RST_RATE_MODE    = 8'h06;
	localparam logic [7:0] RST_SAMPLE_CLK   = 8'hff;
	localparam logic [7:0] RST_REF_CLK      = 8'h5f;

	// bits that hold state; unlisted bits read as zero
	localparam logic [7:0] MASK_PHASE_CTRL  = 8'hcf;
	localparam logic [7:0] MASK_RATE_MODE   = 8'h9f;

	// phase control fields
	localparam int BIT_LOOP_ENABLE   = 7;
	localparam int BIT_DATA_DUTY_FIX = 6;
	localparam int TRIM_W            = 4;
	localparam int TRIM_SIGN         = 3;

	// warning clear and rate mode fields
	localparam int BIT_CLEAR_WARN    = 7;
	localparam int BIT_SLOW_DATA_CLK = 7;
	localparam int BIT_FIXED_DELAY   = 4;

	// status fields
	localparam int STAT_LOCKED       = 7;
	localparam int STAT_NEAR_END     = 6;
	localparam int STAT_AT_START     = 5;
	localparam int STAT_AT_END       = 4;
	localparam int STAT_CLK_PRESENT  = 2;
	localparam int STAT_TRACKING     = 0;
	localparam int WARN_W            = 3;

	// clock receiver fields
	localparam int BIT_DUTY_FIX      = 7;
	localparam int BIT_CROSS_CTRL    = 5;
	localparam int LEVEL_W           = 5;

	// locked phase in hundredths of a degree, and the step count of the base
	localparam int PHASE_BASE_CDEG   = 9000;
	localparam int PHASE_STEP_CDEG   = 1125;
	localparam int PHASE_BASE_STEPS  = PHASE_BASE_CDEG / PHASE_STEP_CDEG;
	localparam int STEPS_W           = 5;

endpackage

// >>> core/drcc_warn_hold.sv
/*
 * drcc_warn_hold: sticky delay-line warning bits with a one-shot clear.
 * Assumes set inputs are synchronous to clock; set wins over clear.
 */
`timescale 1ns/100ps
`default_nettype none

module drcc_warn_hold #(
	parameter int WIDTH = 3
) (
	// clock and control
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             ce,
	// events and clear
	input  wire logic [WIDTH-1:0] set,
	input  wire logic             clear,
	// held bits and new-event pulse
	output logic      [WIDTH-1:0] held,
	output logic                  new_set
);

	typedef struct packed {
		logic [WIDTH-1:0] held;
		logic             new_set;
	} drcc_hold_t;

	drcc_hold_t st_r;
	drcc_hold_t st_nxt;

	// set beats a clear that lands in the same cycle
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.held = (clear ? '0 : st_r.held) | set;
		st_nxt.new_set = |(set & ~st_r.held);
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			st_r <= '0;
		else if (ce)
			st_r <= st_nxt;
	end

	assign held = st_r.held;
	assign new_set = st_r.new_set;

	property p_hold_until_clear;
		@(posedge clock) disable iff (!rst_n)
		(ce && !clear) |=> ((held & $past(held)) == $past(held));
	endproperty
	a_hold_until_clear: assert property (p_hold_until_clear)
		else $error("warning bit dropped without a clear");

	property p_set_beats_clear;
		@(posedge clock) disable iff (!rst_n)
		(ce && clear) |=> (held == $past(set));
	endproperty
	a_set_beats_clear: assert property (p_set_beats_clear)
		else $error("clear did not leave only the new events");

endmodule

`default_nettype wire

// >>> core/drcc_regs.sv
/*
 * drcc_regs: configuration and status bank for the data receiver delay loop
 * and the sample and reference clock input receivers.
 * Assumes the serial configuration engine presents decoded byte reads and
 * writes as one-cycle strobes on clock, and that loop status is synchronous.
 */
`timescale 1ns/100ps
`default_nettype none

module drcc_regs (
	// clock and control
	input  wire logic                          clock,
	input  wire logic                          rst_n,
	input  wire logic                          ce,
	// register port from the serial configuration engine
	input  wire logic [7:0]                    reg_addr,
	input  wire logic [7:0]                    reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [7:0]                    reg_rdata,
	output logic                               reg_rvalid,
	// delay loop status from the receiver
	input  wire logic                          loop_locked,
	input  wire logic                          loop_near_end,
	input  wire logic                          loop_at_start,
	input  wire logic                          loop_at_end,
	input  wire logic                          delay_loop_tracking,
	input  wire logic                          data_clock_present,
	// delay loop and data clock control
	output logic                               loop_enable,
	output logic                               data_clock_duty_fix_on,
	output logic [drcc_pkg::TRIM_W-1:0]        phase_trim,
	output logic [drcc_pkg::STEPS_W-1:0]       locked_phase_steps,
	output logic                               slow_data_clock_mode,
	output logic                               fixed_delay_line_mode,
	output logic [6:0]                         warn_rsv_bits,
	output logic [7:0]                         tuning_bits,
	output logic [3:0]                         mode_rsv_bits,
	// sample clock receiver control
	output logic                               sample_clock_duty_fix_on,
	output logic                               sample_clock_rsv_bit,
	output logic                               sample_clock_crossing_ctrl_on,
	output logic [drcc_pkg::LEVEL_W-1:0]       sample_clock_crossing_level,
	// reference clock receiver control
	output logic                               reference_clock_duty_fix_on,
	output logic                               reference_clock_rsv_bit,
	output logic                               reference_clock_crossing_ctrl_on,
	output logic [drcc_pkg::LEVEL_W-1:0]       reference_clock_crossing_level,
	// events toward the interrupt flag bank
	output logic                               loop_warn_event,
	output logic                               loop_lock_event
);

	typedef struct packed {
		logic [7:0] phase;
		logic [6:0] warn_rsv;
		logic [7:0] tune;
		logic [7:0] mode;
		logic [7:0] sclk;
		logic [7:0] rclk;
		logic       locked;
		logic       tracking;
		logic       present;
		logic [7:0] rdata;
		logic       rvalid;
		logic       lock_evt;
	} drcc_state_t;

	drcc_state_t                       st_r;
	drcc_state_t                       st_nxt;
	logic                              wr_hit_clear;
	logic [drcc_pkg::WARN_W-1:0]       warn_set;
	logic [drcc_pkg::WARN_W-1:0]       warn_held;
	logic                              warn_new;
	logic [7:0]                        status_byte;

	// signed-magnitude trim to steps of 11.25 degrees counted from zero
	function automatic logic [drcc_pkg::STEPS_W-1:0] trim_to_steps(
		input logic [drcc_pkg::TRIM_W-1:0] trim
	);
		logic [drcc_pkg::STEPS_W-1:0] base;
		logic [drcc_pkg::STEPS_W-1:0] mag;
		base = drcc_pkg::STEPS_W'(drcc_pkg::PHASE_BASE_STEPS);
		mag = {2'h0, trim[drcc_pkg::TRIM_SIGN-1:0]};
		if (trim[drcc_pkg::TRIM_SIGN])
			trim_to_steps = base - mag;
		else
			trim_to_steps = base + mag;
	endfunction

	// one-shot clear: acts on the write strobe, never stored
	assign wr_hit_clear = ce && reg_wr && (reg_addr == drcc_pkg::ADDR_WARN_CLEAR)
		&& reg_wdata[drcc_pkg::BIT_CLEAR_WARN];
	assign warn_set = {loop_near_end, loop_at_start, loop_at_end};

	// sticky delay-line warnings
	drcc_warn_hold #(
		.WIDTH (drcc_pkg::WARN_W)
	) u_warn_hold (
		.clock   (clock),
		.rst_n   (rst_n),
		.ce      (ce),
		.set     (warn_set),
		.clear   (wr_hit_clear),
		.held    (warn_held),
		.new_set (warn_new)
	);

	// status byte; reserved bits 3 and 1 read zero
	always_comb
	begin
		status_byte = 8'h00;
		status_byte[drcc_pkg::STAT_LOCKED] = st_r.locked;
		status_byte[drcc_pkg::STAT_NEAR_END] = warn_held[2];
		status_byte[drcc_pkg::STAT_AT_START] = warn_held[1];
		status_byte[drcc_pkg::STAT_AT_END] = warn_held[0];
		status_byte[drcc_pkg::STAT_CLK_PRESENT] = st_r.present;
		status_byte[drcc_pkg::STAT_TRACKING] = st_r.tracking;
	end

	// writes, status capture and read answer
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.locked = loop_locked;
		st_nxt.tracking = delay_loop_tracking;
		st_nxt.present = data_clock_present;
		st_nxt.lock_evt = loop_locked && !st_r.locked;
		st_nxt.rvalid = reg_rd;
		if (reg_wr)
		begin
			case (reg_addr)
				drcc_pkg::ADDR_PHASE_CTRL: st_nxt.phase = reg_wdata & drcc_pkg::MASK_PHASE_CTRL;
				drcc_pkg::ADDR_WARN_CLEAR: st_nxt.warn_rsv = reg_wdata[6:0];
				drcc_pkg::ADDR_TUNING:     st_nxt.tune = reg_wdata;
				drcc_pkg::ADDR_RATE_MODE:  st_nxt.mode = reg_wdata & drcc_pkg::MASK_RATE_MODE;
				drcc_pkg::ADDR_SAMPLE_CLK: st_nxt.sclk = reg_wdata;
				drcc_pkg::ADDR_REF_CLK:    st_nxt.rclk = reg_wdata;
				default:                   st_nxt.phase = st_r.phase; // status is read-only
			endcase
		end
		if (reg_rd)
		begin
			case (reg_addr)
				drcc_pkg::ADDR_PHASE_CTRL: st_nxt.rdata = st_r.phase;
				drcc_pkg::ADDR_WARN_CLEAR: st_nxt.rdata = {1'b0, st_r.warn_rsv};
				drcc_pkg::ADDR_TUNING:     st_nxt.rdata = st_r.tune;
				drcc_pkg::ADDR_RATE_MODE:  st_nxt.rdata = st_r.mode;
				drcc_pkg::ADDR_STATUS:     st_nxt.rdata = status_byte;
				drcc_pkg::ADDR_SAMPLE_CLK: st_nxt.rdata = st_r.sclk;
				drcc_pkg::ADDR_REF_CLK:    st_nxt.rdata = st_r.rclk;
				default:                   st_nxt.rdata = 8'h00;
			endcase
		end
	end

	// state register; reset loads the documented defaults
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			st_r <= '0;
			st_r.phase <= drcc_pkg::RST_PHASE_CTRL;
			st_r.warn_rsv <= drcc_pkg::RST_WARN_RSV;
			st_r.tune <= drcc_pkg::RST_TUNING;
			st_r.mode <= drcc_pkg::RST_RATE_MODE;
			st_r.sclk <= drcc_pkg::RST_SAMPLE_CLK;
			st_r.rclk <= drcc_pkg::RST_REF_CLK;
		end
		else if (ce)
			st_r <= st_nxt;
	end

	// read port
	assign reg_rdata = st_r.rdata;
	assign reg_rvalid = st_r.rvalid;

	// delay loop and data clock control fields
	assign loop_enable = st_r.phase[drcc_pkg::BIT_LOOP_ENABLE];
	assign data_clock_duty_fix_on = st_r.phase[drcc_pkg::BIT_DATA_DUTY_FIX];
	assign phase_trim = st_r.phase[drcc_pkg::TRIM_W-1:0];
	assign locked_phase_steps = trim_to_steps(st_r.phase[drcc_pkg::TRIM_W-1:0]);
	assign slow_data_clock_mode = st_r.mode[drcc_pkg::BIT_SLOW_DATA_CLK];
	assign fixed_delay_line_mode = st_r.mode[drcc_pkg::BIT_FIXED_DELAY];
	assign warn_rsv_bits = st_r.warn_rsv;
	assign tuning_bits = st_r.tune;
	assign mode_rsv_bits = st_r.mode[3:0];

	// clock receiver fields
	assign sample_clock_duty_fix_on = st_r.sclk[drcc_pkg::BIT_DUTY_FIX];
	assign sample_clock_rsv_bit = st_r.sclk[6];
	assign sample_clock_crossing_ctrl_on = st_r.sclk[drcc_pkg::BIT_CROSS_CTRL];
	assign sample_clock_crossing_level = st_r.sclk[drcc_pkg::LEVEL_W-1:0];
	assign reference_clock_duty_fix_on = st_r.rclk[drcc_pkg::BIT_DUTY_FIX];
	assign reference_clock_rsv_bit = st_r.rclk[6];
	assign reference_clock_crossing_ctrl_on = st_r.rclk[drcc_pkg::BIT_CROSS_CTRL];
	assign reference_clock_crossing_level = st_r.rclk[drcc_pkg::LEVEL_W-1:0];

	// events for the interrupt flag bank
	assign loop_warn_event = warn_new;
	assign loop_lock_event = st_r.lock_evt;

	property p_trim_phase;
		@(posedge clock) disable iff (!rst_n)
		phase_trim[3] ? (locked_phase_steps == 5'(8 - {2'h0, phase_trim[2:0]}))
			: (locked_phase_steps == 5'(8 + {2'h0, phase_trim[2:0]}));
	endproperty
	a_trim_phase: assert property (p_trim_phase)
		else $error("locked phase steps disagree with trim");

	property p_loop_enable_write;
		@(posedge clock) disable iff (!rst_n)
		(ce && reg_wr && reg_addr == 8'h0a)
			|=> (loop_enable == $past(reg_wdata[7]))
			&& (data_clock_duty_fix_on == $past(reg_wdata[6]));
	endproperty
	a_loop_enable_write: assert property (p_loop_enable_write)
		else $error("phase control write not applied");

	property p_reset_defaults;
		@(posedge clock)
		!rst_n |=> (!loop_enable && data_clock_duty_fix_on && phase_trim == 4'h0
			&& sample_clock_crossing_level == 5'h1f && !reference_clock_duty_fix_on);
	endproperty
	a_reset_defaults: assert property (p_reset_defaults)
		else $error("reset values wrong");

	property p_sample_clk_write;
		@(posedge clock) disable iff (!rst_n)
		(ce && reg_wr && reg_addr == 8'h10)
			|=> ({sample_clock_duty_fix_on, sample_clock_crossing_ctrl_on,
				sample_clock_crossing_level} == {$past(reg_wdata[7]), $past(reg_wdata[5:0])});
	endproperty
	a_sample_clk_write: assert property (p_sample_clk_write)
		else $error("sample clock receiver write not applied");

	property p_ref_clk_write;
		@(posedge clock) disable iff (!rst_n)
		(ce && reg_wr && reg_addr == 8'h11)
			|=> ({reference_clock_duty_fix_on, reference_clock_crossing_ctrl_on,
				reference_clock_crossing_level} == {$past(reg_wdata[7]), $past(reg_wdata[5:0])});
	endproperty
	a_ref_clk_write: assert property (p_ref_clk_write)
		else $error("reference clock receiver write not applied");

	property p_status_read;
		@(posedge clock) disable iff (!rst_n)
		(ce && reg_rd && reg_addr == 8'h0e && !reg_wr)
			|=> reg_rvalid && (reg_rdata == $past(status_byte)) && (reg_rdata[3] == 1'b0);
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("status read answer wrong");

	property p_tracking_follows;
		@(posedge clock) disable iff (!rst_n)
		ce |=> (status_byte[0] == $past(delay_loop_tracking))
			&& (status_byte[7] == $past(loop_locked));
	endproperty
	a_tracking_follows: assert property (p_tracking_follows)
		else $error("tracking or lock status stale");

	property p_lock_event;
		@(posedge clock) disable iff (!rst_n)
		(ce && loop_locked && !status_byte[7])
			|=> loop_lock_event ##1 (!$past(ce) || !loop_lock_event);
	endproperty
	a_lock_event: assert property (p_lock_event)
		else $error("lock event missing or stretched");

	property p_clear_no_store;
		@(posedge clock) disable iff (!rst_n)
		(ce && reg_rd && reg_addr == 8'h0b) |=> (reg_rdata[7] == 1'b0);
	endproperty
	a_clear_no_store: assert property (p_clear_no_store)
		else $error("clear command bit read back as set");

	property p_warn_clear;
		@(posedge clock) disable iff (!rst_n)
		(wr_hit_clear && warn_set == 3'h0) |=> (status_byte[6:4] == 3'h0);
	endproperty
	a_warn_clear: assert property (p_warn_clear)
		else $error("warning bits not cleared");

endmodule

`default_nettype wire

// >>> verif/drcc_regs_tb.sv
/*
 * drcc_regs_tb: self-checking bench for the data receiver and clock input
 * control bank: reset values, field decode, status and sticky warnings.
 * Assumes drcc_pkg and drcc_regs are compiled before this file.
 */
`timescale 1ns/100ps
`default_nettype none

module drcc_regs_tb;

	// clock and control
	logic        clock;
	logic        rst_n;
	logic        ce;
	// register port
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic        reg_rvalid;
	// loop status inputs, warnings as near/start/end
	logic        loop_locked;
	logic [2:0]  warn_in;
	logic        delay_loop_tracking;
	logic        data_clock_present;
	// decoded outputs
	logic        loop_enable;
	logic        data_clock_duty_fix_on;
	logic [3:0]  phase_trim;
	logic [4:0]  locked_phase_steps;
	logic        slow_data_clock_mode;
	logic        fixed_delay_line_mode;
	logic [6:0]  warn_rsv_bits;
	logic [7:0]  tuning_bits;
	logic [3:0]  mode_rsv_bits;
	logic        sample_clock_duty_fix_on;
	logic        sample_clock_rsv_bit;
	logic        sample_clock_crossing_ctrl_on;
	logic [4:0]  sample_clock_crossing_level;
	logic        reference_clock_duty_fix_on;
	logic        reference_clock_rsv_bit;
	logic        reference_clock_crossing_ctrl_on;
	logic [4:0]  reference_clock_crossing_level;
	logic        loop_warn_event;
	logic        loop_lock_event;
	// bench state
	logic [31:0] seed;
	logic [7:0]  exp_q[$];
	logic [7:0]  addr_tab[8];
	logic [7:0]  a;
	logic [7:0]  v;
	logic [7:0]  st;
	int          error_cnt;
	int          checks_done;
	int          k;

	drcc_regs drcc_regs_i (
		.clock(clock), .rst_n(rst_n), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.loop_locked(loop_locked), .loop_near_end(warn_in[2]),
		.loop_at_start(warn_in[1]), .loop_at_end(warn_in[0]),
		.delay_loop_tracking(delay_loop_tracking), .data_clock_present(data_clock_present),
		.loop_enable(loop_enable), .data_clock_duty_fix_on(data_clock_duty_fix_on),
		.phase_trim(phase_trim), .locked_phase_steps(locked_phase_steps),
		.slow_data_clock_mode(slow_data_clock_mode),
		.fixed_delay_line_mode(fixed_delay_line_mode),
		.warn_rsv_bits(warn_rsv_bits), .tuning_bits(tuning_bits), .mode_rsv_bits(mode_rsv_bits),
		.sample_clock_duty_fix_on(sample_clock_duty_fix_on),
		.sample_clock_rsv_bit(sample_clock_rsv_bit),
		.sample_clock_crossing_ctrl_on(sample_clock_crossing_ctrl_on),
		.sample_clock_crossing_level(sample_clock_crossing_level),
		.reference_clock_duty_fix_on(reference_clock_duty_fix_on),
		.reference_clock_rsv_bit(reference_clock_rsv_bit),
		.reference_clock_crossing_ctrl_on(reference_clock_crossing_ctrl_on),
		.reference_clock_crossing_level(reference_clock_crossing_level),
		.loop_warn_event(loop_warn_event), .loop_lock_event(loop_lock_event)
	);

	// 25 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// register contents rebuilt from the decoded outputs
	function automatic logic [7:0] port_view(input logic [7:0] ad);
		case (ad)
			drcc_pkg::ADDR_PHASE_CTRL: return {loop_enable, data_clock_duty_fix_on, 2'h0, phase_trim};
			drcc_pkg::ADDR_WARN_CLEAR: return {1'b0, warn_rsv_bits};
			drcc_pkg::ADDR_TUNING:     return tuning_bits;
			drcc_pkg::ADDR_RATE_MODE:
				return {slow_data_clock_mode, 2'h0, fixed_delay_line_mode, mode_rsv_bits};
			drcc_pkg::ADDR_SAMPLE_CLK: return {sample_clock_duty_fix_on, sample_clock_rsv_bit,
				sample_clock_crossing_ctrl_on, sample_clock_crossing_level};
			drcc_pkg::ADDR_REF_CLK:    return {reference_clock_duty_fix_on, reference_clock_rsv_bit,
				reference_clock_crossing_ctrl_on, reference_clock_crossing_level};
			default:                   return 8'h00;
		endcase
	endfunction

	// bits that store, per offset
	function automatic logic [7:0] exp_mask(input logic [7:0] ad);
		case (ad)
			drcc_pkg::ADDR_PHASE_CTRL: return drcc_pkg::MASK_PHASE_CTRL;
			drcc_pkg::ADDR_WARN_CLEAR: return 8'h7f;
			drcc_pkg::ADDR_RATE_MODE:  return drcc_pkg::MASK_RATE_MODE;
			drcc_pkg::ADDR_TUNING, drcc_pkg::ADDR_SAMPLE_CLK, drcc_pkg::ADDR_REF_CLK: return 8'hff;
			default:                   return 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] rst_val(input logic [7:0] ad);
		case (ad)
			drcc_pkg::ADDR_PHASE_CTRL: return drcc_pkg::RST_PHASE_CTRL;
			drcc_pkg::ADDR_WARN_CLEAR: return {1'b0, drcc_pkg::RST_WARN_RSV};
			drcc_pkg::ADDR_TUNING:     return drcc_pkg::RST_TUNING;
			drcc_pkg::ADDR_RATE_MODE:  return drcc_pkg::RST_RATE_MODE;
			drcc_pkg::ADDR_SAMPLE_CLK: return drcc_pkg::RST_SAMPLE_CLK;
			drcc_pkg::ADDR_REF_CLK:    return drcc_pkg::RST_REF_CLK;
			default:                   return 8'h00;
		endcase
	endfunction

	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk_port(input string name, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic chk_read(input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED reg_rdata expected %h seen %h", e, g);
		end
	endtask

	// one-cycle write strobe, driven at the falling edge
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(negedge clock);
		reg_addr  = ad;
		reg_wdata = d;
		reg_wr    = 1'b1;
		@(negedge clock);
		reg_wr    = 1'b0;
	endtask

	// one-cycle read strobe; expected data noted for the monitor
	task automatic rd(input logic [7:0] ad, input logic [7:0] e);
		@(negedge clock);
		reg_addr = ad;
		reg_rd   = 1'b1;
		exp_q.push_back(e);
		@(negedge clock);
		reg_rd   = 1'b0;
	endtask

	task automatic check_defaults;
		for (int i = 0; i < 8; i++)
		begin
			if (exp_mask(addr_tab[i]) != 8'h00)
				chk_port("reset view", rst_val(addr_tab[i]), port_view(addr_tab[i]));
			rd(addr_tab[i], rst_val(addr_tab[i]));
		end
		chk_port("locked_phase_steps", 8'h08, {3'h0, locked_phase_steps});
	endtask

	// read data monitor: oldest note against each valid
	always @(negedge clock)
	begin
		if (reg_rvalid === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk_read(8'h00, 8'hxx);
			else
				chk_read(exp_q.pop_front(), reg_rdata);
		end
	end

	// hang guard
	initial
	begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		$display("CHECK FAILED watchdog expected done seen hang");
		report_and_stop();
	end

	// main sequence
	initial
	begin
		error_cnt = 0;
		checks_done = 0;
		seed = 32'h67b8ed02;
		rst_n = 1'b0;
		ce = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		loop_locked = 1'b0;
		warn_in = 3'h0;
		delay_loop_tracking = 1'b0;
		data_clock_present = 1'b0;
		addr_tab = '{drcc_pkg::ADDR_PHASE_CTRL, drcc_pkg::ADDR_WARN_CLEAR, drcc_pkg::ADDR_TUNING,
			drcc_pkg::ADDR_RATE_MODE, drcc_pkg::ADDR_SAMPLE_CLK, drcc_pkg::ADDR_REF_CLK,
			drcc_pkg::ADDR_STATUS, 8'h0f};
		repeat (12) @(negedge clock);
		rst_n = 1'b1;
		check_defaults();
		// every trim code, loop on, duty fix off
		for (k = 0; k < 16; k++)
		begin
			wr(drcc_pkg::ADDR_PHASE_CTRL, {4'h8, k[3:0]});
			chk_port("phase view", {4'h8, k[3:0]}, port_view(drcc_pkg::ADDR_PHASE_CTRL));
			v = k[3] ? 8'h08 - {5'h00, k[2:0]} : 8'h08 + {5'h00, k[2:0]};
			chk_port("locked_phase_steps", v, {3'h0, locked_phase_steps});
		end
		// random writes with decode and readback
		for (k = 0; k < 24; k++)
		begin
			a = addr_tab[k % 6];
			v = seed[7:0];
			seed = xorshift(seed);
			wr(a, v);
			chk_port("field view", v & exp_mask(a), port_view(a));
			rd(a, v & exp_mask(a));
		end
		// read-only and unmapped places
		wr(drcc_pkg::ADDR_STATUS, 8'hff);
		rd(drcc_pkg::ADDR_STATUS, 8'h00);
		wr(8'h0f, 8'h5a);
		rd(8'h0f, 8'h00);
		// frozen clock enable drops a write
		wr(drcc_pkg::ADDR_SAMPLE_CLK, 8'h3c);
		ce = 1'b0;
		wr(drcc_pkg::ADDR_SAMPLE_CLK, 8'hc3);
		ce = 1'b1;
		rd(drcc_pkg::ADDR_SAMPLE_CLK, 8'h3c);
		// rate mode kept to the loop state: loop on below 350 MHz, then fixed line
		wr(drcc_pkg::ADDR_PHASE_CTRL, 8'hc0);
		wr(drcc_pkg::ADDR_RATE_MODE, 8'h86);
		chk_port("slow_data_clock_mode", 8'h01, {7'h0, slow_data_clock_mode});
		chk_port("fixed_delay_line_mode", 8'h00, {7'h0, fixed_delay_line_mode});
		wr(drcc_pkg::ADDR_PHASE_CTRL, 8'h40);
		wr(drcc_pkg::ADDR_RATE_MODE, 8'h16);
		chk_port("fixed_delay_line_mode", 8'h01, {7'h0, fixed_delay_line_mode});
		chk_port("loop_enable", 8'h00, {7'h0, loop_enable});
		// live status and lock event
		wr(drcc_pkg::ADDR_WARN_CLEAR, 8'hb9);
		@(negedge clock);
		loop_locked = 1'b1;
		delay_loop_tracking = 1'b1;
		data_clock_present = 1'b1;
		@(negedge clock);
		chk_port("loop_lock_event", 8'h01, {7'h0, loop_lock_event});
		@(negedge clock);
		chk_port("loop_lock_event", 8'h00, {7'h0, loop_lock_event});
		st = 8'h85;
		rd(drcc_pkg::ADDR_STATUS, st);
		// one-cycle warnings stay held
		for (k = 0; k < 3; k++)
		begin
			@(negedge clock);
			warn_in = 3'h1 << k;
			@(negedge clock);
			warn_in = 3'h0;
			chk_port("loop_warn_event", 8'h01, {7'h0, loop_warn_event});
			st = st | (8'h10 << k);
			rd(drcc_pkg::ADDR_STATUS, st);
			chk_port("loop_warn_event", 8'h00, {7'h0, loop_warn_event});
		end
		// clear together with a new end warning: the new one survives
		@(negedge clock);
		warn_in = 3'h1;
		reg_addr = drcc_pkg::ADDR_WARN_CLEAR;
		reg_wdata = 8'hb9;
		reg_wr = 1'b1;
		@(negedge clock);
		warn_in = 3'h0;
		reg_wr = 1'b0;
		rd(drcc_pkg::ADDR_STATUS, 8'h95);
		wr(drcc_pkg::ADDR_WARN_CLEAR, 8'hb9);
		rd(drcc_pkg::ADDR_WARN_CLEAR, 8'h39);
		rd(drcc_pkg::ADDR_STATUS, 8'h85);
		// second reset in mid-run
		loop_locked = 1'b0;
		delay_loop_tracking = 1'b0;
		data_clock_present = 1'b0;
		@(negedge clock);
		rst_n = 1'b0;
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		check_defaults();
		// bounded drain of outstanding reads
		for (k = 0; k < 8 && exp_q.size() != 0; k++)
			@(negedge clock);
		if (exp_q.size() != 0)
		begin
			error_cnt++;
			$display("CHECK FAILED read drain expected 0 seen %0d", exp_q.size());
		end
		report_and_stop();
	end

endmodule

`default_nettype wire
